//--- bench/ebcs_monitor.sv
// assertion checker for the chip select configuration block
`timescale 1ns/1ns
module ebcs_monitor (
  input wire logic        CLK_IN,                  // clock
  input wire logic        RST_IN,                  // reset
  input wire logic [7:0]  AVS_ADDRESS_IN,          // offset
  input wire logic        AVS_READ_IN,             // read
  input wire logic        AVS_WRITE_IN,            // write
  input wire logic [31:0] AVS_WRITEDATA_IN,        // wdata
  input wire logic [3:0]  AVS_BYTEENABLE_IN,       // lanes
  input wire logic [31:0] AVS_READDATA_OUT,        // rdata
  input wire logic        AVS_WAITREQUEST_OUT,     // stall
  input wire logic [7:0]  FWD_ADDRESS_OUT,         // fwd offset
  input wire logic        FWD_READ_OUT,            // fwd read
  input wire logic        FWD_SEL_DRAM_OUT,        // dram window
  input wire logic        DRAM_WAITREQUEST_IN,     // dram stall
  input wire logic        BOOT_BUS16_OUT,          // boot width
  input wire logic        BOOT_BYTE_SEL_OUT,       // boot mode
  input wire logic        BOOT_RW_BY_CS_OUT,       // boot strobes
  input wire logic [7:0]  SMC_CS_N_IN,             // selects
  input wire logic [22:0] SMC_ADDR_IN,             // address
  input wire logic [31:0] SMC_XFER_ADDR_IN,        // transfer address
  input wire logic        SMC_RD_N_IN,             // read strobe
  input wire logic        READ_N_OUT,              // read pin
  input wire logic [7:0]  CHIP_SELECT_LINES_N_OUT, // select pins
  input wire logic [22:0] ADDR_OUT,                // address pins
  input wire logic [15:0] DATA_PULLUP_EN_OUT,      // pull-ups
  input wire logic        READY_PAD_OUT,           // pad drive
  input wire logic        READY_PAD_OE_OUT,        // pad enable
  input wire logic        CARD_IO_SPACE_OUT        // card io space
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // ========
  // register bus
  sequence s_dram_req;
    FWD_READ_OUT && FWD_SEL_DRAM_OUT && !DRAM_WAITREQUEST_IN;
  endsequence
  sequence s_ack;
    !AVS_WAITREQUEST_OUT;
  endsequence
  property p_ack_one; s_ack |=> AVS_WAITREQUEST_OUT; endproperty
  property p_local_ack; $rose(AVS_READ_IN) && AVS_ADDRESS_IN == 8'h00 |=> s_ack; endproperty
  property p_resv;
    !AVS_WAITREQUEST_OUT && AVS_READ_IN && AVS_ADDRESS_IN inside {8'h08, 8'h0C, [8'h64:8'h9C]}
      |-> AVS_READDATA_OUT == 32'h0;
  endproperty
  property p_fwd_done; s_dram_req |=> s_ack; endproperty
  property p_dram_win; FWD_READ_OUT && FWD_ADDRESS_OUT inside {[8'h30:8'h5C]} |-> FWD_SEL_DRAM_OUT; endproperty
  property p_pullup;
    AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 8'h04 && AVS_BYTEENABLE_IN[0]
      |=> DATA_PULLUP_EN_OUT == {16{!$past(AVS_WRITEDATA_IN[0])}};
  endproperty
  // ========
  // pins
  property p_boot; BOOT_BUS16_OUT && BOOT_BYTE_SEL_OUT && BOOT_RW_BY_CS_OUT; endproperty
  property p_pass;
    CHIP_SELECT_LINES_N_OUT[2] == SMC_CS_N_IN[2] && CHIP_SELECT_LINES_N_OUT[7] == SMC_CS_N_IN[7]
      && ADDR_OUT == SMC_ADDR_IN && READ_N_OUT == SMC_RD_N_IN;
  endproperty
  property p_nand;
    READY_PAD_OE_OUT && (SMC_CS_N_IN[3] || SMC_XFER_ADDR_IN[31:28] != 4'h4) |-> READY_PAD_OUT;
  endproperty
  property p_card; CARD_IO_SPACE_OUT |-> SMC_XFER_ADDR_IN[23]; endproperty
  a_ack_one:   assert property (p_ack_one) else $error("ack longer than one cycle");
  a_local_ack: assert property (p_local_ack) else $error("local read not acked");
  a_resv:      assert property (p_resv) else $error("reserved offset not zero");
  a_fwd_done:  assert property (p_fwd_done) else $error("forwarded read not acked");
  a_dram_win:  assert property (p_dram_win) else $error("dram window not selected");
  a_pullup:    assert property (p_pullup) else $error("pull-ups do not follow write");
  a_boot:      assert property (p_boot) else $error("boot setup wrong");
  a_pass:      assert property (p_pass) else $error("static pins not passed");
  a_nand:      assert property (p_nand) else $error("nand strobe outside space");
  a_card:      assert property (p_card) else $error("card io space without A23");
endmodule : ebcs_monitor

bind ebcs_top ebcs_monitor u_mon (.*);

//--- bench/ebcs_sub_model.sv
// far-side model: sub-controller register ports and shared ready pad
`timescale 1ns/1ns
module ebcs_sub_model (
  input  wire logic        CLK_IN,       // clock
  input  wire logic        FAST_IN,      // answer without stall
  input  wire logic        STROBE_IN,    // forwarded read or write
  input  wire logic [2:0]  SEL_IN,       // smc, dram, bfc windows
  input  wire logic [7:0]  ADDR_IN,      // forwarded offset
  input  wire logic        PAD_OUT_IN,   // device pad drive
  input  wire logic        PAD_OE_IN,    // device pad enable
  input  wire logic        FLASH_RDY_IN, // flash ready level
  output logic      [31:0] RDATA_OUT,    // read data
  output logic             WAIT_OUT,     // stall
  output logic             PAD_OUT       // resolved pad level
);
  logic        wait_q = 1'b1;
  logic [31:0] data;
  assign data = {5'h0, SEL_IN, 16'h5A5A, ADDR_IN};
  // not yet valid data shows inverted so an early sample fails
  assign RDATA_OUT = WAIT_OUT ? ~data : data;
  assign WAIT_OUT = wait_q && !FAST_IN;
  always_ff @(posedge CLK_IN) begin
    wait_q <= !STROBE_IN || !wait_q;
  end
  // whoever enables the shared pad drives it, else the flash ready
  assign PAD_OUT = PAD_OE_IN ? PAD_OUT_IN : FLASH_RDY_IN;
endmodule : ebcs_sub_model

//--- bench/ebcs_top_tb.sv
// self-checking testbench of the chip select configuration block
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module ebcs_top_tb;
  // ports named as the design so the instance connects by name
  logic        CLK_IN = 1'b0, RST_IN = 1'b1, AVS_READ_IN = 1'b0, AVS_WRITE_IN = 1'b0;
  logic [7:0]  AVS_ADDRESS_IN = 8'h00, SMC_CS_N_IN = 8'hFF, FWD_ADDRESS_OUT, CHIP_SELECT_LINES_N_OUT;
  logic [31:0] AVS_WRITEDATA_IN = 32'h0, SMC_XFER_ADDR_IN = 32'h0, AVS_READDATA_OUT, FWD_WRITEDATA_OUT, q;
  logic [3:0]  AVS_BYTEENABLE_IN = 4'hF, FWD_BYTEENABLE_OUT;
  logic [22:0] SMC_ADDR_IN = 23'h0, ADDR_OUT;
  logic        SMC_RD_N_IN = 1'b1, SMC_WE_N_IN = 1'b1, SMC_LO_BYTE_IN = 1'b0, SMC_HI_BYTE_IN = 1'b0;
  logic        SMC_BUS16_IN = 1'b1, SMC_BYTE_SEL_IN = 1'b1, BFC_CS_N_IN = 1'b1, BFC_ADDR_ADV_N_IN = 1'b1;
  logic        DRAM_CS_N_IN = 1'b1, fast = 1'b0, rdy = 1'b0;
  logic        AVS_WAITREQUEST_OUT, FWD_WRITE_OUT, FWD_READ_OUT, FWD_SEL_SMC_OUT, FWD_SEL_DRAM_OUT;
  logic        FWD_SEL_BFC_OUT, BOOT_BUS16_OUT, BOOT_BYTE_SEL_OUT, BOOT_RW_BY_CS_OUT, BFC_READY_OUT;
  logic        ADDR0_LOWER_BYTE_N_OUT, WRITE0_WRITE_STROBE_N_OUT, WRITE1_UPPER_BYTE_N_OUT, READ_N_OUT;
  logic        READY_PAD_OUT, READY_PAD_OE_OUT, ADV_PAD_N_OUT, CARD_DIRECTION_OUT, CARD_IO_SPACE_OUT;
  logic        CARD_REG_SEL_N_OUT, READY_PAD_IN, sub_wait;
  logic [15:0] DATA_PULLUP_EN_OUT;
  logic [31:0] sub_data, SMC_READDATA_IN, DRAM_READDATA_IN, BFC_READDATA_IN;
  logic        SMC_WAITREQUEST_IN, DRAM_WAITREQUEST_IN, BFC_WAITREQUEST_IN;
  int          failures = 0, comparisons = 0;
  logic [7:0]  resv[4] = '{8'h08, 8'h0C, 8'h64, 8'h9C};
  logic [7:0]  win[5] = '{8'h10, 8'h2C, 8'h30, 8'h5C, 8'h60};
  assign {SMC_READDATA_IN, DRAM_READDATA_IN, BFC_READDATA_IN} = {3{sub_data}};
  assign {SMC_WAITREQUEST_IN, DRAM_WAITREQUEST_IN, BFC_WAITREQUEST_IN} = {3{sub_wait}};
  always #50 CLK_IN = ~CLK_IN;
  // pins taken as already in their peripheral function
  ebcs_top u_dut (.*);
  ebcs_sub_model u_sub (
    .CLK_IN(CLK_IN), .FAST_IN(fast), .STROBE_IN(FWD_READ_OUT | FWD_WRITE_OUT),
    .SEL_IN({FWD_SEL_SMC_OUT, FWD_SEL_DRAM_OUT, FWD_SEL_BFC_OUT}), .ADDR_IN(FWD_ADDRESS_OUT),
    .PAD_OUT_IN(READY_PAD_OUT), .PAD_OE_IN(READY_PAD_OE_OUT), .FLASH_RDY_IN(rdy),
    .RDATA_OUT(sub_data), .WAIT_OUT(sub_wait), .PAD_OUT(READY_PAD_IN));
  // ========
  // bus access
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    AVS_ADDRESS_IN <= a;
    AVS_WRITEDATA_IN <= d;
    AVS_WRITE_IN <= w;
    AVS_READ_IN <= !w;
    // no own limit: the watchdog ends a hung access
    do begin @(posedge CLK_IN); end while (AVS_WAITREQUEST_OUT !== 1'b0);
    q = AVS_READDATA_OUT;
    AVS_READ_IN <= 1'b0;
    AVS_WRITE_IN <= 1'b0;
    @(posedge CLK_IN);
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rdc
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (3000) @(posedge CLK_IN);
    failures++;
    results();
  end
  // ========
  // tests
  initial begin
    repeat (4) @(posedge CLK_IN);
    RST_IN <= 1'b0;
    @(posedge CLK_IN);
    `CHK(DATA_PULLUP_EN_OUT, 16'hFFFF)
    rdc(ebcs_pkg::OFS_ROUTING, 32'h0);
    rdc(ebcs_pkg::OFS_PAD_CFG, 32'h0);
    bus(1'b1, 8'h00, 32'hFFFFFFFF);
    rdc(8'h00, 32'h0000001B);
    bus(1'b1, 8'h04, 32'hFFFFFFFF);
    rdc(8'h04, 32'h00000001);
    `CHK(DATA_PULLUP_EN_OUT, 16'h0000)
    foreach (resv[i]) begin
      bus(1'b1, resv[i], 32'hFFFFFFFF);
      rdc(resv[i], 32'h0);
    end
    rdc(8'h00, 32'h0000001B);
    for (int f = 0; f < 2; f++) begin
      fast <= f[0];
      foreach (win[i]) rdc(win[i], {5'h0, win[i] < 8'h30, win[i] inside {[8'h30:8'h5C]},
                                    win[i] == 8'h60, 16'h5A5A, win[i]});
    end
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, 8'h00, r ? 32'h3 : 32'h0);
      BFC_CS_N_IN <= 1'b0;
      DRAM_CS_N_IN <= 1'b0;
      @(negedge CLK_IN);
      `CHK(CHIP_SELECT_LINES_N_OUT[0], !r[0])
      `CHK(CHIP_SELECT_LINES_N_OUT[1], !r[0])
      @(posedge CLK_IN);
    end
    bus(1'b1, 8'h00, 32'h8);
    SMC_CS_N_IN <= 8'hF7;
    SMC_XFER_ADDR_IN <= 32'h40000000;
    SMC_RD_N_IN <= 1'b0;
    BFC_ADDR_ADV_N_IN <= 1'b0;
    @(negedge CLK_IN);
    `CHK({READY_PAD_OE_OUT, ADV_PAD_N_OUT, BFC_READY_OUT}, 3'b110)
    `CHK(READY_PAD_OUT, 1'b0)
    @(posedge CLK_IN);
    SMC_XFER_ADDR_IN <= 32'h50000000;
    @(negedge CLK_IN);
    `CHK(READY_PAD_OUT, 1'b1)
    @(posedge CLK_IN);
    // card bit goes in before any card access
    bus(1'b1, 8'h00, 32'h10);
    SMC_CS_N_IN <= 8'hEF;
    SMC_HI_BYTE_IN <= 1'b1;
    SMC_XFER_ADDR_IN <= 32'h00C00000;
    @(negedge CLK_IN);
    `CHK({CARD_IO_SPACE_OUT, CARD_REG_SEL_N_OUT, CARD_DIRECTION_OUT}, 3'b101)
    `CHK(CHIP_SELECT_LINES_N_OUT[6:4], 3'b010)
    @(posedge CLK_IN);
    bus(1'b1, 8'h00, 32'h0);
    rdy <= 1'b1;
    `CHK({CARD_IO_SPACE_OUT, READY_PAD_OE_OUT}, 2'b00)
    repeat (4) @(posedge CLK_IN);
    @(negedge CLK_IN);
    `CHK(BFC_READY_OUT, 1'b1)
    @(posedge CLK_IN);
    SMC_WE_N_IN <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      SMC_BYTE_SEL_IN <= b[0];
      @(negedge CLK_IN);
      `CHK({WRITE0_WRITE_STROBE_N_OUT, WRITE1_UPPER_BYTE_N_OUT, ADDR0_LOWER_BYTE_N_OUT}, {!b[0], 2'b01})
      @(posedge CLK_IN);
    end
    results();
  end
endmodule : ebcs_top_tb

//--- rtl/ebcs_pin_filter.sv
// three-stage input filter for pins arriving from outside the clock domain
`timescale 1ns/1ns
module ebcs_pin_filter #(
  parameter int W = 1
) (
  input  wire logic         CLK_IN,   // system clock
  input  wire logic         RST_IN,   // sync reset, active high
  input  wire logic [W-1:0] PIN_IN,   // raw pin level
  output logic      [W-1:0] LEVEL_OUT // filtered level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ==========================================================================
  // synchroniser chain; s1 is only read by s2
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= PIN_IN;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================================
  // a change counts once the last two stages agree
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      LEVEL_OUT <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          LEVEL_OUT[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : ebcs_pin_filter

//--- rtl/ebcs_top.sv
// external bus chip select routing, pad configuration and register forwarding
//
// How it works
// - select 0 from static or burst flash
// - select 1 from static or DRAM
// - select 3 bit enables NAND logic
// - select 4 bit enables card logic
// - pull-up bit low enables data pull-ups
// - two registers at 0x00, 0x04, reset zero
// - forward offset windows to sub-controllers
// - select 0 boots byte-select, 16-bit, CS-qualified
// - A23 picks I/O space, A22 register select
// - eight selects, 23-bit address, 16-bit data
// - shared pins follow width and access type
// - card mode: selects 4-6 carry card signals
// - NAND strobes replace burst flash pins
// - NAND strobes only inside select-3 space
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
module ebcs_top (
  input  wire logic        CLK_IN,               // system clock, 10 MHz
  input  wire logic        RST_IN,               // sync reset, active high
  // avalon-mm slave
  input  wire logic [7:0]  AVS_ADDRESS_IN,       // byte offset in block
  input  wire logic        AVS_READ_IN,          // read request
  input  wire logic        AVS_WRITE_IN,         // write request
  input  wire logic [31:0] AVS_WRITEDATA_IN,     // write data
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,    // byte lanes
  output logic      [31:0] AVS_READDATA_OUT,     // read data
  output logic             AVS_WAITREQUEST_OUT,  // stall
  // forwarded register port, shared by the three sub-controllers
  output logic      [7:0]  FWD_ADDRESS_OUT,      // offset, held from request
  output logic      [31:0] FWD_WRITEDATA_OUT,    // write data
  output logic      [3:0]  FWD_BYTEENABLE_OUT,   // byte lanes
  output logic             FWD_WRITE_OUT,        // write strobe
  output logic             FWD_READ_OUT,         // read strobe
  output logic             FWD_SEL_SMC_OUT,      // static controller window
  output logic             FWD_SEL_DRAM_OUT,     // DRAM controller window
  output logic             FWD_SEL_BFC_OUT,      // burst flash window
  input  wire logic [31:0] SMC_READDATA_IN,      // static ctrl read data
  input  wire logic        SMC_WAITREQUEST_IN,   // static ctrl stall
  input  wire logic [31:0] DRAM_READDATA_IN,     // DRAM ctrl read data
  input  wire logic        DRAM_WAITREQUEST_IN,  // DRAM ctrl stall
  input  wire logic [31:0] BFC_READDATA_IN,      // burst ctrl read data
  input  wire logic        BFC_WAITREQUEST_IN,   // burst ctrl stall
  // select-0 boot setup to the static controller
  output logic             BOOT_BUS16_OUT,       // 16-bit data bus
  output logic             BOOT_BYTE_SEL_OUT,    // byte-select access
  output logic             BOOT_RW_BY_CS_OUT,    // strobes qualified by CS
  // static controller side
  input  wire logic [7:0]  SMC_CS_N_IN,          // selects, active low
  input  wire logic [22:0] SMC_ADDR_IN,          // external address
  input  wire logic [31:0] SMC_XFER_ADDR_IN,     // internal transfer address
  input  wire logic        SMC_RD_N_IN,          // read strobe, active low
  input  wire logic        SMC_WE_N_IN,          // write strobe, active low
  input  wire logic        SMC_LO_BYTE_IN,       // lower byte accessed
  input  wire logic        SMC_HI_BYTE_IN,       // upper byte accessed
  input  wire logic        SMC_BUS16_IN,         // current select is 16-bit
  input  wire logic        SMC_BYTE_SEL_IN,      // current select byte-select
  // other controllers
  input  wire logic        BFC_CS_N_IN,          // burst flash select
  input  wire logic        BFC_ADDR_ADV_N_IN,    // burst address advance
  output logic             BFC_READY_OUT,        // filtered ready to burst ctrl
  input  wire logic        DRAM_CS_N_IN,         // DRAM select
  // external pins
  output logic      [7:0]  CHIP_SELECT_LINES_N_OUT, // select pins
  output logic      [22:0] ADDR_OUT,             // address pins
  output logic             ADDR0_LOWER_BYTE_N_OUT,  // A0 or lower byte
  output logic             WRITE0_WRITE_STROBE_N_OUT, // write0 or write
  output logic             WRITE1_UPPER_BYTE_N_OUT,   // write1 or upper byte
  output logic             READ_N_OUT,           // read strobe pin
  output logic      [15:0] DATA_PULLUP_EN_OUT,   // pull-up per data line
  input  wire logic        READY_PAD_IN,         // ready/read pad level
  output logic             READY_PAD_OUT,        // ready/read pad drive
  output logic             READY_PAD_OE_OUT,     // ready/read pad enable
  output logic             ADV_PAD_N_OUT,        // advance/write pad
  output logic             CARD_DIRECTION_OUT,   // card buffer dir, 1 = read
  output logic             CARD_IO_SPACE_OUT,    // card I/O space
  output logic             CARD_REG_SEL_N_OUT    // card attribute select
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACK  = 3'b100
  } ebcs_state_t;

  typedef enum logic [2:0] {
    TG_LOCAL = 3'b001,
    TG_SMC   = 3'b010,
    TG_DRAM  = 3'b011,
    TG_BFC   = 3'b100
  } ebcs_target_t;

  ebcs_state_t  state_q;
  ebcs_state_t  state_d;
  ebcs_target_t target_q;
  ebcs_target_t req_target;
  logic [31:0]  routing_q;
  logic [31:0]  pad_cfg_q;
  logic [31:0]  rdata_q;
  logic [7:0]   addr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   be_q;
  logic         wr_q;
  logic         req;
  logic         sub_wait;
  logic [31:0]  sub_rdata;
  logic         sel0_bfc;
  logic         sel1_dram;
  logic         nand_en;
  logic         card_en;
  logic         nand_window;
  logic         nand_rd_n;
  logic         nand_wr_n;
  logic         card_sel;
  logic         ready_lvl;

  // ==========================================================================
  // helpers
  function automatic ebcs_target_t decode(input logic [7:0] ofs);
    if (ofs >= ebcs_pkg::OFS_SMC_LO && ofs <= ebcs_pkg::OFS_SMC_HI) begin
      decode = TG_SMC;
    end else if (ofs >= ebcs_pkg::OFS_DRAM_LO && ofs <= ebcs_pkg::OFS_DRAM_HI) begin
      decode = TG_DRAM;
    end else if (ofs == ebcs_pkg::OFS_BFC) begin
      decode = TG_BFC;
    end else begin
      decode = TG_LOCAL;
    end
  endfunction : decode

  function automatic logic [31:0] lane_write(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be,
                                             input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    lane_write = (old & ~m) | (wd & m);
  endfunction : lane_write

  function automatic logic [31:0] local_read(input logic [7:0] ofs,
                                             input logic [31:0] rt,
                                             input logic [31:0] pc);
    if (ofs == ebcs_pkg::OFS_ROUTING) begin
      local_read = rt & ebcs_pkg::ROUTING_MASK;
    end else if (ofs == ebcs_pkg::OFS_PAD_CFG) begin
      local_read = pc & ebcs_pkg::PAD_CFG_MASK;
    end else begin
      local_read = 32'h00000000;
    end
  endfunction : local_read

  // ==========================================================================
  // bus slave state machine
  assign req        = AVS_READ_IN | AVS_WRITE_IN;
  assign req_target = decode(AVS_ADDRESS_IN);

  always_comb begin
    case (target_q)
      TG_SMC: begin
        sub_wait  = SMC_WAITREQUEST_IN;
        sub_rdata = SMC_READDATA_IN;
      end
      TG_DRAM: begin
        sub_wait  = DRAM_WAITREQUEST_IN;
        sub_rdata = DRAM_READDATA_IN;
      end
      TG_BFC: begin
        sub_wait  = BFC_WAITREQUEST_IN;
        sub_rdata = BFC_READDATA_IN;
      end
      default: begin
        sub_wait  = 1'b0;
        sub_rdata = 32'h00000000;
      end
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (req && req_target == TG_LOCAL) begin
          state_d = ST_ACK;
        end else if (req) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!sub_wait) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // request captured once; master holds it until the answer anyway
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      target_q <= TG_LOCAL;
      addr_q   <= 8'h00;
      wdata_q  <= 32'h00000000;
      be_q     <= 4'h0;
      wr_q     <= 1'b0;
    end else if (state_q == ST_IDLE && req) begin
      target_q <= req_target;
      addr_q   <= AVS_ADDRESS_IN;
      wdata_q  <= AVS_WRITEDATA_IN;
      be_q     <= AVS_BYTEENABLE_IN;
      wr_q     <= AVS_WRITE_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rdata_q <= 32'h00000000;
    end else if (state_q == ST_IDLE && req && req_target == TG_LOCAL) begin
      rdata_q <= AVS_READ_IN ? local_read(AVS_ADDRESS_IN, routing_q, pad_cfg_q) : 32'h00000000;
    end else if (state_q == ST_WAIT && !sub_wait) begin
      rdata_q <= wr_q ? 32'h00000000 : sub_rdata;
    end
  end

  assign AVS_WAITREQUEST_OUT = (state_q != ST_ACK);
  assign AVS_READDATA_OUT    = rdata_q;

  // forwarded strobes stand only while waiting on the sub-controller
  assign FWD_ADDRESS_OUT    = addr_q;
  assign FWD_WRITEDATA_OUT  = wdata_q;
  assign FWD_BYTEENABLE_OUT = be_q;
  assign FWD_WRITE_OUT      = (state_q == ST_WAIT) & wr_q;
  assign FWD_READ_OUT       = (state_q == ST_WAIT) & ~wr_q;
  assign FWD_SEL_SMC_OUT    = (state_q == ST_WAIT) & (target_q == TG_SMC);
  assign FWD_SEL_DRAM_OUT   = (state_q == ST_WAIT) & (target_q == TG_DRAM);
  assign FWD_SEL_BFC_OUT    = (state_q == ST_WAIT) & (target_q == TG_BFC);

  // ==========================================================================
  // local registers, written on the edge that completes the access
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      routing_q <= ebcs_pkg::ROUTING_RESET;
    end else if (state_q == ST_ACK && wr_q && target_q == TG_LOCAL && addr_q == ebcs_pkg::OFS_ROUTING) begin
      routing_q <= lane_write(routing_q, wdata_q, be_q, ebcs_pkg::ROUTING_MASK);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pad_cfg_q <= ebcs_pkg::PAD_CFG_RESET;
    end else if (state_q == ST_ACK && wr_q && target_q == TG_LOCAL && addr_q == ebcs_pkg::OFS_PAD_CFG) begin
      pad_cfg_q <= lane_write(pad_cfg_q, wdata_q, be_q, ebcs_pkg::PAD_CFG_MASK);
    end
  end

  assign sel0_bfc  = routing_q[ebcs_pkg::BIT_SEL0_ROUTE];
  assign sel1_dram = routing_q[ebcs_pkg::BIT_SEL1_ROUTE];
  assign nand_en   = routing_q[ebcs_pkg::BIT_SEL3_NAND];
  assign card_en   = routing_q[ebcs_pkg::BIT_SEL4_CARD];

  // ==========================================================================
  // boot setup; constant so select 0 works before software runs
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      BOOT_BUS16_OUT    <= ebcs_pkg::BOOT_BUS16;
      BOOT_BYTE_SEL_OUT <= ebcs_pkg::BOOT_BYTE_SEL;
      BOOT_RW_BY_CS_OUT <= ebcs_pkg::BOOT_RW_BY_CS;
    end else begin
      BOOT_BUS16_OUT    <= ebcs_pkg::BOOT_BUS16;
      BOOT_BYTE_SEL_OUT <= ebcs_pkg::BOOT_BYTE_SEL;
      BOOT_RW_BY_CS_OUT <= ebcs_pkg::BOOT_RW_BY_CS;
    end
  end

  // ==========================================================================
  // pad pull-ups
  assign DATA_PULLUP_EN_OUT = {ebcs_pkg::DATA_W{~pad_cfg_q[ebcs_pkg::BIT_PULLUP_DIS]}};

  // ==========================================================================
  // chip select routing
  assign card_sel = ~SMC_CS_N_IN[4];

  always_comb begin
    CHIP_SELECT_LINES_N_OUT    = SMC_CS_N_IN;
    CHIP_SELECT_LINES_N_OUT[0] = sel0_bfc ? BFC_CS_N_IN : SMC_CS_N_IN[0];
    CHIP_SELECT_LINES_N_OUT[1] = sel1_dram ? DRAM_CS_N_IN : SMC_CS_N_IN[1];
    if (card_en) begin
      // card chip select has the same timing as select 4
      CHIP_SELECT_LINES_N_OUT[4] = SMC_CS_N_IN[4];
      CHIP_SELECT_LINES_N_OUT[5] = ~(card_sel & SMC_LO_BYTE_IN);
      CHIP_SELECT_LINES_N_OUT[6] = ~(card_sel & SMC_HI_BYTE_IN);
    end
  end

  // ==========================================================================
  // card address decode; only meaningful while the card is selected
  assign CARD_IO_SPACE_OUT  = card_en & SMC_XFER_ADDR_IN[ebcs_pkg::CARD_IO_BIT];
  assign CARD_REG_SEL_N_OUT = ~(card_en & SMC_XFER_ADDR_IN[ebcs_pkg::CARD_REG_BIT]);
  assign CARD_DIRECTION_OUT = card_en & card_sel & SMC_WE_N_IN;

  // ==========================================================================
  // shared address and strobe pins
  assign ADDR_OUT   = SMC_ADDR_IN;
  assign READ_N_OUT = SMC_RD_N_IN;

  always_comb begin
    ADDR0_LOWER_BYTE_N_OUT = SMC_BUS16_IN ? ~SMC_LO_BYTE_IN : SMC_ADDR_IN[0];
    if (SMC_BYTE_SEL_IN) begin
      WRITE0_WRITE_STROBE_N_OUT = SMC_WE_N_IN;
      WRITE1_UPPER_BYTE_N_OUT   = ~SMC_HI_BYTE_IN;
    end else begin
      WRITE0_WRITE_STROBE_N_OUT = SMC_WE_N_IN | ~SMC_LO_BYTE_IN;
      WRITE1_UPPER_BYTE_N_OUT   = SMC_WE_N_IN | ~SMC_HI_BYTE_IN;
    end
  end

  // ==========================================================================
  // NAND strobes share the burst flash ready and advance pads;
  // burst flash loses ready while NAND mode is on
  assign nand_window = ~SMC_CS_N_IN[3] & (SMC_XFER_ADDR_IN[31:28] == ebcs_pkg::NAND_SPACE_TOP);
  assign nand_rd_n   = ~(nand_en & nand_window & ~SMC_RD_N_IN);
  assign nand_wr_n   = ~(nand_en & nand_window & ~SMC_WE_N_IN);

  assign READY_PAD_OE_OUT = nand_en;
  assign READY_PAD_OUT    = nand_en ? nand_rd_n : 1'b1;
  assign ADV_PAD_N_OUT    = nand_en ? nand_wr_n : BFC_ADDR_ADV_N_IN;

  ebcs_pin_filter #(
    .W (ebcs_pkg::SYNC_W)
  ) u_ready_filter (
    .CLK_IN    (CLK_IN),
    .RST_IN    (RST_IN),
    .PIN_IN    (READY_PAD_IN),
    .LEVEL_OUT (ready_lvl)
  );

  assign BFC_READY_OUT = ready_lvl & ~nand_en;
endmodule : ebcs_top

//--- shared/ebcs_pkg.sv
// constants shared by the external bus chip select configuration block
package ebcs_pkg;
  // ==========================================================================
  // register map (byte offsets within the block)
  localparam logic [31:0] BASE_ADDR      = 32'hFFFFFF60;
  localparam logic [7:0]  OFS_ROUTING    = 8'h00;
  localparam logic [7:0]  OFS_PAD_CFG    = 8'h04;
  localparam logic [7:0]  OFS_SMC_LO     = 8'h10;
  localparam logic [7:0]  OFS_SMC_HI     = 8'h2C;
  localparam logic [7:0]  OFS_DRAM_LO    = 8'h30;
  localparam logic [7:0]  OFS_DRAM_HI    = 8'h5C;
  localparam logic [7:0]  OFS_BFC        = 8'h60;
  // ==========================================================================
  // field positions
  localparam int          BIT_SEL0_ROUTE = 0;
  localparam int          BIT_SEL1_ROUTE = 1;
  localparam int          BIT_SEL3_NAND  = 3;
  localparam int          BIT_SEL4_CARD  = 4;
  localparam int          BIT_PULLUP_DIS = 0;
  localparam logic [31:0] ROUTING_MASK   = 32'h0000001B;
  localparam logic [31:0] PAD_CFG_MASK   = 32'h00000001;
  // ==========================================================================
  // reset values
  localparam logic [31:0] ROUTING_RESET  = 32'h00000000;
  localparam logic [31:0] PAD_CFG_RESET  = 32'h00000000;
  // select-0 boot setup handed to the static controller
  localparam logic        BOOT_BUS16     = 1'b1;
  localparam logic        BOOT_BYTE_SEL  = 1'b1;
  localparam logic        BOOT_RW_BY_CS  = 1'b1;
  // ==========================================================================
  // select-3 address space, top nibble of the transfer address
  localparam logic [3:0]  NAND_SPACE_TOP = 4'h4;
  // card address bits
  localparam int          CARD_IO_BIT    = 23;
  localparam int          CARD_REG_BIT   = 22;
  // external bus sizes
  localparam int          NUM_SEL        = 8;
  localparam int          ADDR_W         = 23;
  localparam int          DATA_W         = 16;
  localparam int          SYNC_W         = 1;
endpackage : ebcs_pkg
